// ### hdl/pmc_device.sv
/*
  MAC-side control and status register bank with clock output gating.
  Assumes the controller holds req until ack and that FIFO event,
  power-down and energy-detect inputs are synchronous to sys_clk_i.
*/
// Overview of operation
// - Software initialises bias word one to 0x0003
// - Software initialises bias word two to 0x0000
// - Depth field selects elastic depth, resets 00
// - Fast clock stop bit follows strap, gates output
// - Slow clock stop bit loads and tracks strap
// - Slow stop bit holds slow clock low
// - Fast stop and rx bits act after soft reset
// - Rx clock runs unless bit clear and powered down or energy detected
// - Three enable bits gate FIFO interrupts, reset 0
// - Overflow/underflow status latches high, resets 0
// - Idle inserted status latches high, resets 0
// - Idle deleted status latches high, resets 0
// - Reserved bit seven resets to one always
// - Reserved status bits always read zero
module pmc_device
  import pmc_pkg::*;
(
  input  logic        sys_clk_i,
  input  logic        rst_i,
  pmc_link_if.dev     link,
  input  logic        strap_stop_fast_clock_i,
  input  logic        strap_stop_slow_clock_i,
  input  logic        fifo_xrun_i,
  input  logic        fifo_idle_ins_i,
  input  logic        fifo_idle_del_i,
  input  logic        power_down_i,
  input  logic        energy_detect_i,
  output logic        clock_out_125mhz_o,
  output logic        clock_out_50mhz_o,
  output logic        rx_clk_run_o,
  output logic [1:0]  fifo_depth_o,
  output logic [15:0] bias_word_one_o,
  output logic [15:0] bias_word_two_o
);

  logic [15:0] ctrl_q,   ctrl_d;
  logic [15:0] ien_q,    ien_d;
  logic [2:0]  stat_q,   stat_d;
  logic [15:0] bias1_q,  bias1_d;
  logic [15:0] bias2_q,  bias2_d;
  logic        act125_q, act125_d;
  logic        actrx_q,  actrx_d;
  logic        ack_q,    ack_d;
  logic [15:0] rdata_q,  rdata_d;
  logic        irq_q,    irq_d;
  logic [1:0]  meta_q,   meta_d;
  logic [1:0]  sync_q,   sync_d;
  logic [1:0]  prev_q,   prev_d;
  logic        ld_q,     ld_d;
  logic [1:0]  settle_q, settle_d;
  logic [7:0]  fcnt_q,   fcnt_d;
  logic [7:0]  scnt_q,   scnt_d;
  logic        fclk_q,   fclk_d;
  logic        sclk_q,   sclk_d;
  logic        rxrun_q,  rxrun_d;
  logic        take;

  always_comb
  begin
    ctrl_d   = ctrl_q;
    ien_d    = ien_q;
    stat_d   = stat_q;
    bias1_d  = bias1_q;
    bias2_d  = bias2_q;
    act125_d = act125_q;
    actrx_d  = actrx_q;
    rdata_d  = rdata_q;
    meta_d   = {strap_stop_slow_clock_i, strap_stop_fast_clock_i};
    sync_d   = meta_q;
    prev_d   = sync_q;
    ld_d     = ld_q;
    settle_d = settle_q;
    take     = link.req && !ack_q;
    ack_d    = take;

    if (take && link.we)
    begin
      unique case (link.addr)
        REG_CTRL1: ctrl_d  = link.wdata;
        REG_IEN:   ien_d   = link.wdata;
        REG_BIAS1: bias1_d = link.wdata;
        REG_BIAS2: bias2_d = link.wdata;
        default:   ;
      endcase
    end
    else if (take)
    begin
      unique case (link.addr)
        REG_CTRL1: rdata_d = ctrl_q;
        REG_IEN:   rdata_d = ien_q;
        REG_STAT:  rdata_d = {8'h00, stat_q[2], 3'h0,
                              stat_q[1:0], 2'h0};
        REG_BIAS1: rdata_d = bias1_q;
        REG_BIAS2: rdata_d = bias2_q;
        default:   rdata_d = 16'h0000;
      endcase
      if (link.addr == REG_STAT)
      begin
        stat_d = 3'h0;
      end
    end

    // Strap load after reset, then follow strap edges
    if (!ld_q)
    begin
      settle_d = settle_q + 2'h1;
      if (settle_q == STRAP_SETTLE)
      begin
        ld_d                 = 1'b1;
        ctrl_d[CTRL_STOP125] = sync_q[0];
        ctrl_d[CTRL_STOP50]  = sync_q[1];
        act125_d             = sync_q[0];
      end
    end
    else
    begin
      if (sync_q[0] != prev_q[0])
      begin
        ctrl_d[CTRL_STOP125] = sync_q[0];
      end
      if (sync_q[1] != prev_q[1])
      begin
        ctrl_d[CTRL_STOP50] = sync_q[1];
      end
    end

    if (link.soft_rst)
    begin
      ctrl_d[CTRL_RSVD_ONE] = 1'b1;
      act125_d = ctrl_q[CTRL_STOP125];
      actrx_d  = ctrl_q[CTRL_RXRUN];
      stat_d   = 3'h0;
    end

    // Set wins over read clear
    if (fifo_xrun_i)
    begin
      stat_d[2] = 1'b1;
    end
    if (fifo_idle_ins_i)
    begin
      stat_d[1] = 1'b1;
    end
    if (fifo_idle_del_i)
    begin
      stat_d[0] = 1'b1;
    end

    irq_d = |(stat_q & {ien_q[EV_XRUN], ien_q[EV_INS],
                        ien_q[EV_DEL]});
    rxrun_d = actrx_q || !(power_down_i || energy_detect_i);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q   <= CTRL1_RST;
      ien_q    <= IEN_RST;
      stat_q   <= 3'h0;
      bias1_q  <= BIAS_RST;
      bias2_q  <= BIAS_RST;
      act125_q <= 1'b0;
      actrx_q  <= 1'b1;
      ack_q    <= 1'b0;
      rdata_q  <= 16'h0000;
      irq_q    <= 1'b0;
      meta_q   <= 2'h0;
      sync_q   <= 2'h0;
      prev_q   <= 2'h0;
      ld_q     <= 1'b0;
      settle_q <= 2'h0;
      rxrun_q  <= 1'b1;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      ien_q    <= ien_d;
      stat_q   <= stat_d;
      bias1_q  <= bias1_d;
      bias2_q  <= bias2_d;
      act125_q <= act125_d;
      actrx_q  <= actrx_d;
      ack_q    <= ack_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
      meta_q   <= meta_d;
      sync_q   <= sync_d;
      prev_q   <= prev_d;
      ld_q     <= ld_d;
      settle_q <= settle_d;
      rxrun_q  <= rxrun_d;
    end
  end

  // Clock output dividers
  always_comb
  begin
    fcnt_d = fcnt_q;
    scnt_d = scnt_q;
    fclk_d = fclk_q;
    sclk_d = sclk_q;
    if (act125_q)
    begin
      fcnt_d = 8'h00;
      fclk_d = 1'b0;
    end
    else if (fcnt_q == 8'(FAST_HALF - 1))
    begin
      fcnt_d = 8'h00;
      fclk_d = !fclk_q;
    end
    else
    begin
      fcnt_d = fcnt_q + 8'h01;
    end
    if (ctrl_q[CTRL_STOP50])
    begin
      scnt_d = 8'h00;
      sclk_d = 1'b0;
    end
    else if (scnt_q == 8'(SLOW_HALF - 1))
    begin
      scnt_d = 8'h00;
      sclk_d = !sclk_q;
    end
    else
    begin
      scnt_d = scnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fcnt_q <= 8'h00;
      scnt_q <= 8'h00;
      fclk_q <= 1'b0;
      sclk_q <= 1'b0;
    end
    else
    begin
      fcnt_q <= fcnt_d;
      scnt_q <= scnt_d;
      fclk_q <= fclk_d;
      sclk_q <= sclk_d;
    end
  end

  assign link.ack           = ack_q;
  assign link.rdata         = rdata_q;
  assign link.irq           = irq_q;
  assign clock_out_125mhz_o = fclk_q;
  assign clock_out_50mhz_o  = sclk_q;
  assign rx_clk_run_o       = rxrun_q;
  assign fifo_depth_o       = ctrl_q[CTRL_DEPTH_LO +: 2];
  assign bias_word_one_o    = bias1_q;
  assign bias_word_two_o    = bias2_q;

endmodule : pmc_device

// ### hdl/pmc_pkg.sv
/*
  Shared constants for the MAC-side control and status bank and its
  management controller. Assumes a single 125 MHz system clock.
*/
package pmc_pkg;

  // Device register numbers on the management link
  localparam logic [4:0]  REG_CTRL1      = 5'h10;
  localparam logic [4:0]  REG_IEN        = 5'h12;
  localparam logic [4:0]  REG_STAT       = 5'h13;
  localparam logic [4:0]  REG_BIAS1      = 5'h1d;
  localparam logic [4:0]  REG_BIAS2      = 5'h1e;

  // Control word one fields and values after reset
  localparam int          CTRL_DEPTH_LO  = 14;
  localparam int          CTRL_STOP125   = 9;
  localparam int          CTRL_STOP50    = 8;
  localparam int          CTRL_RSVD_ONE  = 7;
  localparam int          CTRL_RXRUN     = 3;
  localparam logic [15:0] CTRL1_RST      = 16'h0088;
  localparam logic [15:0] IEN_RST        = 16'h0000;
  localparam logic [15:0] BIAS_RST       = 16'h0000;

  // Interrupt enable and status bit positions
  localparam int          EV_XRUN        = 7;
  localparam int          EV_INS         = 3;
  localparam int          EV_DEL         = 2;

  // Strap settling count after reset release
  localparam logic [1:0]  STRAP_SETTLE   = 2'h2;

  // Clock output dividers
  localparam int          SYS_HZ         = 125_000_000;
  localparam int          FAST_HZ        = 125_000_000;
  localparam int          SLOW_HZ        = 50_000_000;
  localparam int          FAST_HALF      = (SYS_HZ / (2 * FAST_HZ)) < 1 ?
                                           1 : SYS_HZ / (2 * FAST_HZ);
  localparam int          SLOW_HALF      = (SYS_HZ / (2 * SLOW_HZ)) < 1 ?
                                           1 : SYS_HZ / (2 * SLOW_HZ);

  // Controller word addresses on the Avalon-MM slave
  localparam logic [2:0]  HA_PHY_REG     = 3'h0;
  localparam logic [2:0]  HA_WDATA       = 3'h1;
  localparam logic [2:0]  HA_CMD         = 3'h2;
  localparam logic [2:0]  HA_RESULT      = 3'h3;
  localparam logic [2:0]  HA_IRQ_STAT    = 3'h4;
  localparam logic [2:0]  HA_IRQ_MASK    = 3'h5;
  localparam int          CMD_READ       = 0;
  localparam int          CMD_WRITE      = 1;
  localparam int          CMD_SOFT_RST   = 2;
  localparam int          IRQ_DONE       = 0;
  localparam int          IRQ_PHY        = 1;
  localparam int          RESULT_BUSY    = 16;

  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } pmc_state_e;

endpackage : pmc_pkg

// ### hdl/pmc_link_if.sv
/*
  Management link between the controller and the register bank.
  Both ends run on the same clock; no crossing is needed.
*/
interface pmc_link_if;
  logic        req;
  logic        we;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        soft_rst;
  logic        ack;
  logic [15:0] rdata;
  logic        irq;

  modport dev
  (
    input  req, we, addr, wdata, soft_rst,
    output ack, rdata, irq
  );

  modport host
  (
    output req, we, addr, wdata, soft_rst,
    input  ack, rdata, irq
  );
endinterface : pmc_link_if

// ### hdl/pmc_host.sv
/*
  Management controller: Avalon-MM slave with waitrequest that runs
  reads, writes and soft resets on the register bank link.
  Assumes the bank answers each request with a one-cycle ack.
*/
module pmc_host
  import pmc_pkg::*;
(
  input  logic        sys_clk_i,
  input  logic        rst_i,
  input  logic [2:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  output logic        irq_o,
  pmc_link_if.host    link
);

  pmc_state_e  st_q,    st_d;
  logic        wait_q,  wait_d;
  logic [31:0] rd_q,    rd_d;
  logic [4:0]  preg_q,  preg_d;
  logic [15:0] wdat_q,  wdat_d;
  logic [15:0] res_q,   res_d;
  logic [1:0]  ist_q,   ist_d;
  logic [1:0]  imsk_q,  imsk_d;
  logic        irq_q,   irq_d;
  logic        req_q,   req_d;
  logic        we_q,    we_d;
  logic        srst_q,  srst_d;
  logic        acc;
  logic        wr;

  always_comb
  begin
    st_d   = st_q;
    rd_d   = rd_q;
    preg_d = preg_q;
    wdat_d = wdat_q;
    res_d  = res_q;
    ist_d  = ist_q;
    imsk_d = imsk_q;
    req_d  = req_q;
    we_d   = we_q;
    srst_d = 1'b0;
    acc    = (avs_read || avs_write) && !wait_q;
    wr     = acc && avs_write;
    wait_d = !((avs_read || avs_write) && wait_q);

    if ((avs_read || avs_write) && wait_q)
    begin
      unique case (avs_address)
        HA_PHY_REG:  rd_d = {27'h0, preg_q};
        HA_WDATA:    rd_d = {16'h0, wdat_q};
        HA_RESULT:   rd_d = {15'h0, st_q == ST_WAIT, res_q};
        HA_IRQ_STAT: rd_d = {30'h0, ist_q};
        HA_IRQ_MASK: rd_d = {30'h0, imsk_q};
        default:     rd_d = 32'h0;
      endcase
    end

    if (wr)
    begin
      unique case (avs_address)
        HA_PHY_REG:  preg_d = avs_writedata[4:0];
        HA_WDATA:    wdat_d = avs_writedata[15:0];
        HA_IRQ_STAT: ist_d  = ist_q & ~avs_writedata[1:0];
        HA_IRQ_MASK: imsk_d = avs_writedata[1:0];
        default:     ;
      endcase
    end

    unique case (st_q)
      ST_IDLE:
      begin
        if (wr && avs_address == HA_CMD)
        begin
          if (avs_writedata[CMD_SOFT_RST])
          begin
            srst_d = 1'b1;
          end
          else if (avs_writedata[CMD_WRITE] || avs_writedata[CMD_READ])
          begin
            req_d = 1'b1;
            we_d  = avs_writedata[CMD_WRITE];
            st_d  = ST_WAIT;
          end
        end
      end
      ST_WAIT:
      begin
        if (link.ack)
        begin
          req_d = 1'b0;
          st_d  = ST_IDLE;
          ist_d[IRQ_DONE] = 1'b1;
          if (!we_q)
          begin
            res_d = link.rdata;
          end
        end
      end
    endcase

    // Events win over a same-cycle clear
    if (link.irq)
    begin
      ist_d[IRQ_PHY] = 1'b1;
    end
    irq_d = |(ist_q & imsk_q);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q   <= ST_IDLE;
      wait_q <= 1'b1;
      rd_q   <= 32'h0;
      preg_q <= 5'h00;
      wdat_q <= 16'h0000;
      res_q  <= 16'h0000;
      ist_q  <= 2'h0;
      imsk_q <= 2'h0;
      irq_q  <= 1'b0;
      req_q  <= 1'b0;
      we_q   <= 1'b0;
      srst_q <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      wait_q <= wait_d;
      rd_q   <= rd_d;
      preg_q <= preg_d;
      wdat_q <= wdat_d;
      res_q  <= res_d;
      ist_q  <= ist_d;
      imsk_q <= imsk_d;
      irq_q  <= irq_d;
      req_q  <= req_d;
      we_q   <= we_d;
      srst_q <= srst_d;
    end
  end

  assign avs_readdata    = rd_q;
  assign avs_waitrequest = wait_q;
  assign irq_o           = irq_q;
  assign link.req        = req_q;
  assign link.we         = we_q;
  assign link.addr       = preg_q;
  assign link.wdata      = wdat_q;
  assign link.soft_rst   = srst_q;

endmodule : pmc_host

// ### testbench/pmc_link_checker.sv
/*
  Checker on the bank link: answer timing, request holding and readback.
  Assumes it sits beside the link interface, on sys_clk_i and rst_i.
*/
module pmc_link_checker
  import pmc_pkg::*;
(
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        req,
  input wire logic        we,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        soft_rst,
  input wire logic        ack,
  input wire logic [15:0] rdata,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] b1_q, b2_q, ien_q;
  logic [1:0]  dep_q;
  logic        r7_q;
  logic        wa, ra;
  assign wa = ack & req & we;
  assign ra = ack & req & !we;
  // Shadow of the last values written
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      {b1_q, b2_q, ien_q, dep_q, r7_q} <= {50'h0, 1'b1};
    else if (soft_rst)
      r7_q <= 1'b1;
    else if (wa)
    begin
      if (addr == REG_BIAS1)
        b1_q <= wdata;
      if (addr == REG_BIAS2)
        b2_q <= wdata;
      if (addr == REG_IEN)
        ien_q <= wdata;
      if (addr == REG_CTRL1)
        {dep_q, r7_q} <= {wdata[15:14], wdata[7]};
    end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ack_pulse;
    ack ##1 !ack;
  endsequence
  property p_ack_pulse;
    $rose(req) |=> s_ack_pulse;
  endproperty
  property p_req_hold;
    req && !ack |=> req && $stable({we, addr, wdata});
  endproperty
  property p_stat_rsvd;
    ra && addr == REG_STAT |-> (rdata & 16'hff73) == 16'h0000;
  endproperty
  property p_depth;
    ra && addr == REG_CTRL1 |-> rdata[15:14] == dep_q;
  endproperty
  property p_rsvd_one;
    ra && addr == REG_CTRL1 |-> rdata[7] == r7_q;
  endproperty
  property p_bias1;
    ra && addr == REG_BIAS1 |-> rdata == b1_q;
  endproperty
  property p_bias2;
    ra && addr == REG_BIAS2 |-> rdata == b2_q;
  endproperty
  property p_ien;
    ra && addr == REG_IEN |-> (rdata & 16'h008c) == (ien_q & 16'h008c);
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bank ack not one cycle after request");
  a_req_hold: assert property (p_req_hold)
    else $error("host request changed before ack");
  a_stat_rsvd: assert property (p_stat_rsvd)
    else $error("status reserved bits not zero");
  a_depth: assert property (p_depth)
    else $error("depth field readback wrong");
  a_rsvd_one: assert property (p_rsvd_one)
    else $error("control bit seven readback wrong");
  a_bias1: assert property (p_bias1)
    else $error("bias word one readback wrong");
  a_bias2: assert property (p_bias2)
    else $error("bias word two readback wrong");
  a_ien: assert property (p_ien)
    else $error("enable readback wrong");
  property p_irq_gate;
    irq |-> (ien_q & 16'h008c) != 16'h0000;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("bank interrupt with no enable set");
endmodule : pmc_link_checker

// ### testbench/tb_top.sv
/*
  Testbench: controller and bank joined by the link, driven over Avalon.
  Assumes the package constants and the link interface of the design.
*/
module tb_top
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [2:0]  av_a = 3'h0;
  logic        av_rd = 1'b0, av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0, av_q, rd;
  logic        av_wait, irq_o, c125, c50, rx_run;
  logic        st_fast = 1'b1, st_slow = 1'b0, pdn = 1'b0, edet = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [1:0]  depth;
  logic [15:0] b1, b2;
  logic [4:0]  rr [4] = '{REG_IEN, REG_STAT, REG_BIAS1, REG_BIAS2};
  int          err_total = 0;
  int          comparisons = 0;
  int          cyc = 0;
  pmc_link_if link ();
  pmc_device u_pmc_device (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .link(link), .strap_stop_fast_clock_i(st_fast),
    .strap_stop_slow_clock_i(st_slow), .fifo_xrun_i(ev[2]),
    .fifo_idle_ins_i(ev[1]), .fifo_idle_del_i(ev[0]),
    .power_down_i(pdn), .energy_detect_i(edet),
    .clock_out_125mhz_o(c125), .clock_out_50mhz_o(c50),
    .rx_clk_run_o(rx_run), .fifo_depth_o(depth),
    .bias_word_one_o(b1), .bias_word_two_o(b2));
  pmc_host u_pmc_host (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .avs_address(av_a), .avs_read(av_rd), .avs_write(av_wr),
    .avs_writedata(av_wd), .avs_readdata(av_q),
    .avs_waitrequest(av_wait), .irq_o(irq_o), .link(link));
  pmc_link_checker u_pmc_link_checker (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .req(link.req), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .soft_rst(link.soft_rst), .ack(link.ack),
    .rdata(link.rdata), .irq(link.irq));
  always #4 sys_clk_i = ~sys_clk_i;
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
    av_a <= a;
    av_wr <= w;
    av_rd <= !w;
    av_wd <= d;
    @(posedge sys_clk_i);
    while (av_wait !== 1'b0)
      @(posedge sys_clk_i);
    rd = av_q;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge sys_clk_i);
  endtask : av
  // Bank command through the controller, polled until not busy
  task automatic phy(input logic [4:0] r, input logic [2:0] c,
                     input logic [15:0] d);
    av(1'b1, HA_PHY_REG, {27'h0, r});
    av(1'b1, HA_WDATA, {16'h0, d});
    av(1'b1, HA_CMD, {29'h0, c});
    rd = 32'h0001_0000;
    while (rd[RESULT_BUSY] !== 1'b0)
      av(1'b0, HA_RESULT, 32'h0);
  endtask : phy
  task automatic clk_chk(input logic t125, input logic t50);
    logic a, b;
    a = c125;
    b = c50;
    @(posedge sys_clk_i);
    chk({12'h0, a ^ c125, b ^ c50, c125 & !t125, c50 & !t50},
        {12'h0, t125, t50, 2'b00});
  endtask : clk_chk
  task automatic pulse(input logic [2:0] m);
    ev <= m;
    @(posedge sys_clk_i);
    ev <= 3'h0;
    repeat (4) @(posedge sys_clk_i);
  endtask : pulse
  initial
  begin
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (9) @(posedge sys_clk_i);
    // Reset values
    phy(REG_CTRL1, 3'h1, 16'h0);
    chk(rd[15:0], CTRL1_RST | 16'h0200);
    clk_chk(1'b0, 1'b1);
    chk({15'h0, rx_run}, 16'h1);
    foreach (rr[i])
    begin
      phy(rr[i], 3'h1, 16'h0);
      chk(rd[15:0], 16'h0);
    end
    $display("test reset done");
    // Bias words kept over soft reset
    phy(REG_BIAS1, 3'h2, 16'h0003);
    phy(REG_BIAS2, 3'h2, 16'h5a5a);
    phy(5'h0, 3'h4, 16'h0);
    phy(REG_BIAS1, 3'h1, 16'h0);
    chk(rd[15:0], 16'h0003);
    chk(b1, 16'h0003);
    chk(b2, 16'h5a5a);
    phy(REG_BIAS2, 3'h2, 16'h0000);
    chk(b2, 16'h0000);
    $display("test bias done");
    // Every depth code
    for (int d = 0; d < 4; d++)
    begin
      phy(REG_CTRL1, 3'h2, {d[1:0], 14'h0288});
      chk({14'h0, depth}, d[15:0]);
    end
    $display("test depth done");
    // Strap edges and clock gating
    st_slow <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    clk_chk(1'b0, 1'b0);
    phy(REG_CTRL1, 3'h1, 16'h0);
    chk(rd[15:0], 16'hc388);
    st_slow <= 1'b0;
    st_fast <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    clk_chk(1'b0, 1'b1);
    phy(REG_CTRL1, 3'h1, 16'h0);
    chk(rd[15:0], 16'hc088);
    $display("test straps done");
    // Receive clock bit and bit seven after soft reset
    pdn <= 1'b1;
    phy(REG_CTRL1, 3'h2, 16'h0000);
    repeat (3) @(posedge sys_clk_i);
    chk({15'h0, rx_run}, 16'h1);
    phy(5'h0, 3'h4, 16'h0);
    repeat (3) @(posedge sys_clk_i);
    chk({15'h0, rx_run}, 16'h0);
    clk_chk(1'b1, 1'b1);
    phy(REG_CTRL1, 3'h1, 16'h0);
    chk(rd[15:0], 16'h0080);
    pdn <= 1'b0;
    edet <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk({15'h0, rx_run}, 16'h0);
    edet <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk({15'h0, rx_run}, 16'h1);
    $display("test rx clock done");
    // FIFO events, enables, read clear and interrupt
    av(1'b1, HA_IRQ_MASK, 32'h2);
    phy(REG_IEN, 3'h2, 16'h0084);
    av(1'b1, HA_IRQ_STAT, 32'h3);
    pulse(3'b110);
    chk({15'h0, irq_o}, 16'h1);
    av(1'b0, HA_IRQ_STAT, 32'h0);
    chk(rd[15:0], 16'h0002);
    phy(REG_STAT, 3'h1, 16'h0);
    chk(rd[15:0], 16'h0088);
    phy(REG_STAT, 3'h1, 16'h0);
    chk(rd[15:0], 16'h0000);
    av(1'b1, HA_IRQ_STAT, 32'h3);
    pulse(3'b010);
    chk({15'h0, irq_o}, 16'h0);
    pulse(3'b001);
    chk({15'h0, irq_o}, 16'h1);
    av(1'b1, HA_IRQ_MASK, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    chk({15'h0, irq_o}, 16'h0);
    phy(REG_STAT, 3'h1, 16'h0);
    chk(rd[15:0], 16'h000c);
    $display("test events done");
    final_report();
  end
endmodule : tb_top
